// ==== prsca_pkg.sv ====
// package for the peripheral register window decoder with set/clear/read aliases
// Overview of operation
// - three addresses reach one stored register
// - first alias sets, second clears, third reads
// - ones written set or clear bits
// - zeros written leave bits unchanged
// - 16 Kbyte windows in top 3 Mbyte
// - interrupt controller window is 4 Kbyte
// - base at window bottom, offsets count upward
// - little-endian byte lanes on multi-byte access
package prsca_pkg;

  // ==========================================================
  // address map
  localparam logic [31:0] PRSCA_REGION_BASE = 32'hFFD0_0000; // bottom of top 3 Mbyte
  localparam logic [31:0] PRSCA_INTC_BASE   = 32'hFFFF_F000; // top 4 Kbyte
  localparam int          PRSCA_WIN_BITS    = 14;            // 16 Kbyte peripheral window
  localparam int          PRSCA_INTC_BITS   = 12;            // 4 Kbyte controller window
  localparam int          PRSCA_SLOT_BITS   = 8;             // slots in 3 Mbyte region

  // ==========================================================
  // alias layout inside one register group
  localparam int          PRSCA_GROUP_BITS  = 4;             // 16 bytes per register group
  localparam logic [3:0]  PRSCA_OFS_SET     = 4'h0;
  localparam logic [3:0]  PRSCA_OFS_CLR     = 4'h4;
  localparam logic [3:0]  PRSCA_OFS_READ    = 4'h8;
  localparam logic [31:0] PRSCA_REG_RESET   = 32'h0000_0000;

  // ==========================================================
  // bus carriers
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0]  strb;   // lane 0 is bits 7:0
  } prsca_req_t;

  typedef struct packed {
    logic        valid;
    logic        err;
    logic [31:0] rdata;
  } prsca_resp_t;

endpackage

// ==== prsca_decoder.sv ====
// peripheral window decoder and aliased set/clear/read register bank
`timescale 1ns/10ps
module prsca_decoder #(
  parameter int NUM_PERIPH = 16,
  parameter int LOCAL_IDX  = 0,
  parameter int NUM_REGS   = 4
) (
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire prsca_pkg::prsca_req_t req,
  output prsca_pkg::prsca_resp_t     resp,
  output logic [NUM_PERIPH-1:0]      periph_sel,
  output logic                       intc_sel,
  output logic [13:0]                win_offset,
  output logic [NUM_REGS*32-1:0]     reg_value
);
  import prsca_pkg::*;

  localparam int IDXW = (NUM_REGS > 1) ? $clog2(NUM_REGS) : 1;

  // ==========================================================
  // map notes
  // - region starts at the bottom of the top 3 Mbyte
  // - slot i is peripheral i, 16 Kbyte each, counting up
  // - slots at or above NUM_PERIPH are unmapped holes
  // - controller window is the last 4 Kbyte of the space
  // - controller window sits inside an unused high slot
  // - so it is tested first and wins over that slot
  // - below the region nothing is mapped at all
  //
  // register group notes
  // - group k starts at byte k*16 of the local window
  // - +0 sets bits, +4 clears bits, +8 reads the word
  // - +C and any group at or above NUM_REGS is ignored
  // - writing the read alias has no effect
  // - reading a set or clear alias returns zero
  //
  // response notes
  // - answered one cycle after the request is taken
  // - only the local window and holes are answered here
  // - other windows answer on their own from their select
  // - a hole answers with the error flag raised
  // - rdata is zero unless a read alias was hit
  //
  // limitations
  // - word access only; strobes mask whole byte lanes
  // - one bus means set and clear never meet in a cycle
  // - the clear-after-set order is kept anyway so that a
  //   second port added later stays deterministic
  // - selects are combinational and follow req directly;
  //   a glitchy req gives glitchy selects

  // ==========================================================
  // window decode
  logic [31:0]                diff;
  logic [PRSCA_SLOT_BITS-1:0] slot;
  logic                       intc_hit;
  logic                       periph_hit;
  logic                       local_hit;
  logic [IDXW-1:0]            reg_idx;
  logic                       reg_ok;
  logic [3:0]                 alias_ofs;
  logic [31:0]                lane_mask;

  // base is lowest address; offsets count upward from it
  always_comb begin
    diff       = req.addr - PRSCA_REGION_BASE;
    slot       = diff[PRSCA_WIN_BITS +: PRSCA_SLOT_BITS];
    win_offset = diff[PRSCA_WIN_BITS-1:0];
    reg_idx    = req.addr[PRSCA_GROUP_BITS +: IDXW];
    reg_ok     = (32'(req.addr[PRSCA_WIN_BITS-1:PRSCA_GROUP_BITS]) < NUM_REGS);
    alias_ofs  = req.addr[PRSCA_GROUP_BITS-1:0];
    intc_hit   = 1'b0;
    periph_hit = 1'b0;
    local_hit  = 1'b0;
    // below the region only the error path answers
    if (req.addr < PRSCA_REGION_BASE) begin
      intc_hit   = 1'b0;
    end else if (req.addr[31:PRSCA_INTC_BITS] == PRSCA_INTC_BASE[31:PRSCA_INTC_BITS]) begin
      // the controller window wins over the slot it sits in
      intc_hit   = 1'b1;
    end else if (32'(slot) < NUM_PERIPH) begin
      periph_hit = 1'b1;
      local_hit  = (32'(slot) == LOCAL_IDX);
    end else begin
      // unused slots above the last peripheral stay unmapped
      periph_hit = 1'b0;
    end
    intc_sel   = req.valid && intc_hit;
  end

  // little-endian lanes: strb[0] covers the least significant byte
  always_comb begin
    lane_mask = {{8{req.strb[3]}}, {8{req.strb[2]}}, {8{req.strb[1]}}, {8{req.strb[0]}}};
  end

  // one select per peripheral window; the local bank keeps its own
  genvar g;
  generate
    for (g = 0; g < NUM_PERIPH; g++) begin : g_sel
      assign periph_sel[g] = req.valid && periph_hit && (32'(slot) == g) && (g != LOCAL_IDX);
    end
  endgenerate

  // ==========================================================
  // aliased register bank
  logic        wr_set;
  logic        wr_clr;
  logic        rd_val;
  logic [31:0] regs_reg  [NUM_REGS];
  logic [31:0] regs_next [NUM_REGS];

  // alias decode; wrong direction on an alias is ignored
  always_comb begin
    wr_set = 1'b0;
    wr_clr = 1'b0;
    rd_val = 1'b0;
    if (!(req.valid && local_hit && reg_ok)) begin
      wr_set = 1'b0;
    end else if (req.write && (alias_ofs == PRSCA_OFS_SET)) begin
      wr_set = 1'b1;
    end else if (req.write && (alias_ofs == PRSCA_OFS_CLR)) begin
      wr_clr = 1'b1;
    end else if (!req.write && (alias_ofs == PRSCA_OFS_READ)) begin
      rd_val = 1'b1;
    end else begin
      // spare offset or refused direction: no effect
      rd_val = 1'b0;
    end
  end

  generate
    for (g = 0; g < NUM_REGS; g++) begin : g_reg
      logic [31:0] set_m;
      logic [31:0] clr_m;
      // all three aliases land on this one stored word
      always_comb begin
        set_m = (wr_set && (32'(reg_idx) == g)) ? (req.wdata & lane_mask) : 32'h0000_0000;
        clr_m = (wr_clr && (32'(reg_idx) == g)) ? (req.wdata & lane_mask) : 32'h0000_0000;
        // zero bits leave state alone; clear ordered after set
        regs_next[g] = (regs_reg[g] | set_m) & ~clr_m;
      end
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          regs_reg[g] <= PRSCA_REG_RESET;
        end else begin
          regs_reg[g] <= regs_next[g];
        end
      end
      assign reg_value[g*32 +: 32] = regs_reg[g];
    end
  endgenerate

  // ==========================================================
  // response: local window and unmapped space only; other
  // peripherals answer on their own after seeing their select
  prsca_resp_t resp_reg;
  prsca_resp_t resp_next;

  always_comb begin
    resp_next.valid = req.valid && (local_hit || !(periph_hit || intc_hit));
    resp_next.err   = req.valid && !(periph_hit || intc_hit);
    resp_next.rdata = rd_val ? regs_reg[reg_idx] : 32'h0000_0000;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      resp_reg <= '0;
    end else begin
      resp_reg <= resp_next;
    end
  end

  assign resp = resp_reg;

endmodule // prsca_decoder

// ==== prsca_checker_properties.sv ====
// concurrent checks on the decoder ports
`timescale 1ns/10ps
module prsca_checker
  import prsca_pkg::*;
#(parameter int NUM_PERIPH = 16, parameter int LOCAL_IDX = 0, parameter int NUM_REGS = 4) (
  input wire logic                   mclk,
  input wire logic                   rst_n,
  input wire prsca_pkg::prsca_req_t  req,
  input wire prsca_pkg::prsca_resp_t resp,
  input wire logic [NUM_PERIPH-1:0]  periph_sel,
  input wire logic                   intc_sel,
  input wire logic [13:0]            win_offset,
  input wire logic [NUM_REGS*32-1:0] reg_value
);
  import prsca_pkg::*;
  // ==========================================
  // group 0 of the local window; p_hold alone watches every group
  logic [31:0] lb;
  logic        w0;
  assign lb = PRSCA_REGION_BASE + 32'(LOCAL_IDX) * 32'h0000_4000;
  assign w0 = req.valid && req.write && req.addr[31:4] == lb[31:4];
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_set; w0 && req.addr[3:0] == 4'h0 && req.strb == 4'hF |=> reg_value[31:0] == ($past(reg_value[31:0]) | $past(req.wdata)); endproperty
  a_set: assert property (p_set) else $error("set alias wrong");
  property p_keep; w0 && req.addr[3:0] == 4'h4 |=> (reg_value[31:0] | $past(req.wdata)) == ($past(reg_value[31:0]) | $past(req.wdata)); endproperty
  a_keep: assert property (p_keep) else $error("clear touched zero bits");
  property p_rd; req.valid && !req.write && req.addr == lb + 32'h0000_0008 |=> resp.valid && resp.rdata == $past(reg_value[31:0]); endproperty
  a_rd: assert property (p_rd) else $error("read alias wrong");
  property p_hold; !$past(req.valid) |-> $stable(reg_value); endproperty
  a_hold: assert property (p_hold) else $error("register moved idle");
  property p_unm; req.valid && req.addr < PRSCA_REGION_BASE |=> resp.valid && resp.err; endproperty
  a_unm: assert property (p_unm) else $error("unmapped not flagged");
  property p_ofs; req.valid |-> win_offset == 14'(req.addr - PRSCA_REGION_BASE); endproperty
  a_ofs: assert property (p_ofs) else $error("offset wrong");
  property p_intc; intc_sel == (req.valid && req.addr[31:12] == 20'hF_FFFF); endproperty
  a_intc: assert property (p_intc) else $error("controller select wrong");
  property p_lane; w0 && req.addr[3:0] == 4'h0 && req.strb == 4'h1 |=> reg_value[31:8] == $past(reg_value[31:8]); endproperty
  a_lane: assert property (p_lane) else $error("masked lane written");
endmodule // prsca_checker

// ==== prsca_host_model.sv ====
// processor side model: one request per clock edge
`timescale 1ns/10ps
module prsca_host (
  input wire logic            mclk,
  output prsca_pkg::prsca_req_t req
);
  import prsca_pkg::*;
  initial req = '0;
  // word access, lane 0 carries bits 7:0
  task automatic acc(input logic w, input logic [31:0] a, d, input logic [3:0] s);
    @(posedge mclk);
    req <= '{1'b1, w, a, d, s};
  endtask
  // release after the taking edge
  task automatic idle;
    @(posedge mclk);
    req <= '0;
  endtask
endmodule // prsca_host

// ==== peripheral_reg_set_clear_alias_bench.sv ====
// self-checking bench for the aliased register decoder
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module peripheral_reg_set_clear_alias_bench;
  import prsca_pkg::*;
  localparam logic [31:0] L = PRSCA_REGION_BASE;
  logic         mclk = 1'b0;
  logic         rst_n = 1'b0;
  prsca_req_t   req;
  prsca_resp_t  resp;
  logic [15:0]  psel;
  logic         isel;
  logic [13:0]  wofs;
  logic [127:0] rv;
  int           n_errors = 0;
  int           n_tests = 0;
  int           cyc = 0;
  prsca_host u_host (.mclk(mclk), .req(req));
  prsca_decoder u_dut (.mclk(mclk), .rst_n(rst_n), .req(req), .resp(resp), .periph_sel(psel), .intc_sel(isel),
    .win_offset(wofs), .reg_value(rv));
  // ==========================================
  // clock and a watchdog well past the short run
  initial forever #5 mclk = ~mclk;
  always @(posedge mclk) if (++cyc > 500) begin n_errors++; report_and_stop(); end
  // one access, release, let the answer land
  task automatic rw(input logic w, input logic [31:0] a, d, input logic [3:0] s);
    u_host.acc(w, a, d, s);
    u_host.idle();
    #1;
  endtask
  // set, clear, read back and a single lane
  task automatic t_alias;
    rw(1, L, 32'hA5A5_00FF, 4'hF);
    `CHK("set", 32'hA5A5_00FF, rv[31:0])
    rw(1, L + 4, 32'h0000_000F, 4'hF);
    `CHK("clr", 32'hA5A5_00F0, rv[31:0])
    rw(0, L + 8, 0, 0);
    `CHK("rd", 32'hA5A5_00F0, resp.rdata)
    `CHK("other", 32'h0000_0000, rv[63:32])
    rw(1, L, 32'h1122_330F, 4'h1);
    `CHK("lane", 32'hA5A5_00FF, rv[31:0])
    $display("t_alias done");
  endtask
  // refused aliases and a second group
  task automatic t_refuse;
    rw(1, L + 8, 32'hFFFF_FFFF, 4'hF);
    `CHK("wr_rd", 32'hA5A5_00FF, rv[31:0])
    rw(0, L, 0, 0);
    `CHK("rd_set", 32'h0000_0000, resp.rdata)
    `CHK("rd_vld", 1'b1, resp.valid)
    `CHK("rd_err", 1'b0, resp.err)
    rw(1, L + 16, 32'h0000_8001, 4'hF);
    `CHK("grp1", 32'h0000_8001, rv[63:32])
    $display("t_refuse done");
  endtask
  // window selects, offset, controller and unmapped
  task automatic t_map;
    u_host.acc(0, L + 32'h0000_4020, 0, 0);
    #1 `CHK("sel", 16'h0002, psel)
    `CHK("ofs", 14'h0020, wofs)
    u_host.acc(0, 32'hFFFF_F010, 0, 0);
    #1 `CHK("intc", 1'b1, isel)
    rw(0, 32'h0000_1000, 0, 0);
    `CHK("err", 1'b1, resp.err)
    `CHK("err_vld", 1'b1, resp.valid)
    $display("t_map done");
  endtask
  task automatic report_and_stop;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // reset for three cycles, then the scenarios
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    t_alias();
    t_refuse();
    t_map();
    report_and_stop();
  end
endmodule // peripheral_reg_set_clear_alias_bench
bind prsca_decoder prsca_checker #(.NUM_PERIPH(NUM_PERIPH), .LOCAL_IDX(LOCAL_IDX), .NUM_REGS(NUM_REGS)) u_chk (
  .mclk(mclk), .rst_n(rst_n), .req(req), .resp(resp), .periph_sel(periph_sel), .intc_sel(intc_sel),
  .win_offset(win_offset), .reg_value(reg_value));
